// [core/gwa_regs.svh]
// Command codes, field positions, reset values and timing figures for the
// window addressing, scroll and tearing block. Definitions only.
`ifndef GWA_REGS_SVH
`define GWA_REGS_SVH

// Command opcodes
`define GWA_OP_SLEEP_IN 8'h10
`define GWA_OP_SLEEP_OUT 8'h11
`define GWA_OP_PARTIAL_ON 8'h12
`define GWA_OP_NORMAL_ON 8'h13
`define GWA_OP_COL_WIN 8'h2a
`define GWA_OP_PAGE_WIN 8'h2b
`define GWA_OP_MEM_WR 8'h2c
`define GWA_OP_MEM_RD 8'h2e
`define GWA_OP_PART_AREA 8'h30
`define GWA_OP_SCROLL_DEF 8'h33
`define GWA_OP_TE_OFF 8'h34
`define GWA_OP_TE_ON 8'h35
`define GWA_OP_ACCESS_CTL 8'h36
`define GWA_OP_SCROLL_START 8'h37
`define GWA_OP_IDLE_OFF 8'h38
`define GWA_OP_IDLE_ON 8'h39

// Access control and tearing mode parameter bit positions
`define GWA_BIT_ROW_MIRROR 7
`define GWA_BIT_COL_MIRROR 6
`define GWA_BIT_EXCHANGE 5
`define GWA_BIT_SCAN_FLIP 4
`define GWA_BIT_RB_SWAP 3
`define GWA_BIT_TE_MODE 0

// Resolution select codes
`define GWA_GM_128 2'h1
`define GWA_GM_160 2'h3

// Mirror bases and line counts
`define GWA_COL_TOP 16'h007f
`define GWA_PAGE_TOP_128 16'h007f
`define GWA_PAGE_TOP_160 16'h00a1
`define GWA_LINES_128 16'h0080
`define GWA_LINES_160 16'h00a0
`define GWA_FRAME_LINES 16'h00b5

// Reset values of windows and areas
`define GWA_RST_END_COL 16'h007f
`define GWA_RST_END_PAGE 16'h009f
`define GWA_RST_SCROLL_AREA 16'h00a0

// Timing: clock rate, frame rate, least vertical blank high time
`define GWA_CLK_HZ 250000000
`define GWA_FRAME_HZ 60
`define GWA_TVDH_MIN_US 1000
`define GWA_LINE_CYCLES (`GWA_CLK_HZ / (`GWA_FRAME_HZ * 181))
`define GWA_TVDH_MIN_CYCLES ((`GWA_TVDH_MIN_US * (`GWA_CLK_HZ / 1000000)))
`define GWA_HPULSE_CYCLES 16'h0010

`endif

// [core/gwa_pkg.sv]
// Types shared by the window addressing, scroll and tearing block.
// Assumes the constants header is included by the design file.
package gwa_pkg;

  typedef struct packed {
    logic row_mirror;
    logic column_mirror;
    logic row_column_exchange;
    logic scan_order_flip;
    logic rb_swap;
  } gwa_access_t;

  typedef struct packed {
    logic [5:0] r;
    logic [5:0] g;
    logic [5:0] b;
  } gwa_pixel_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [15:0] p0;
    logic [15:0] p1;
    logic [15:0] p2;
  } gwa_cmd_t;

  typedef struct packed {
    logic [6:0] col;
    logic [7:0] page;
  } gwa_addr_t;

  typedef enum logic [2:0] {
    GWA_DISP_NORMAL = 3'b001,
    GWA_DISP_PARTIAL = 3'b010,
    GWA_DISP_SCROLL = 3'b100
  } gwa_disp_t;

  typedef enum logic [1:0] {
    GWA_ACC_WRITE = 2'b01,
    GWA_ACC_READ = 2'b10
  } gwa_acc_t;

  typedef enum logic [4:0] {
    GWA_PWR_FULL = 5'b00001,
    GWA_PWR_PARTIAL = 5'b00010,
    GWA_PWR_FULL_IDLE = 5'b00100,
    GWA_PWR_PARTIAL_IDLE = 5'b01000,
    GWA_PWR_SLEEP = 5'b10000
  } gwa_power_t;

endpackage

// [core/gwa_top.sv]
// Display memory address counter, panel line timing and tearing output,
// with a pixel FIFO in front of the memory write port.
// Assumes commands arrive already decoded on the same clock, one per cycle.
//
// Overview of operation
// - Step address one pixel per memory access
// - Keep counter inside the programmed window
// - Memory write/read reloads start column, page
// - Each pixel advances column, page stays
// - Column past end: reload, next page
// - Page past end: reload both counters
// - 160 lines: mirror page 161, column 127
// - Exchange swaps column and page windows
// - 128 lines: mirror both as 127 minus
// - Normal view: columns 0-127, pages 0-159
// - Access bits: D7 D6 D5 D4 D3 mapping
// - Scan flip reverses gate scan order
// - Red/blue bit swaps sub-pixel order
// - Scroll start enters vertical scroll mapping
// - Partial mode shows only start-end rows
// - Tearing output on/off with mode
// - Mode 0: high blank lines, low active; mode 1 adds line start pulses
// - Blank high time at least 1000 us
// - Idle mode reduces to eight colours
// - Sleep stops timing, keeps memory access
// - Commands move among five power levels
`timescale 1ns/1ps
`include "gwa_regs.svh"

// Pixel FIFO with registered full and empty flags
module gwa_fifo #(
  parameter int W = 18,
  parameter int D = 8
) (
  input wire logic clock, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic in_valid, // Write side valid
  input wire logic [W-1:0] in_data, // Write side data
  output logic in_ready, // Write side ready
  input wire logic out_ready, // Read side ready
  output logic out_valid, // Read side valid
  output logic [W-1:0] out_data // Read side data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic full;
    logic empty;
  } gwa_fifo_st_t;

  gwa_fifo_st_t s_q;
  gwa_fifo_st_t s_d;
  logic push;
  logic pop;

  assign push = in_valid & ~s_q.full;
  assign pop = out_ready & ~s_q.empty;
  assign in_ready = ~s_q.full;
  assign out_valid = ~s_q.empty;
  assign out_data = s_q.mem[s_q.rp];

  // Pointer and count update
  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = (s_q.wp == AW'(D - 1)) ? '0 : s_q.wp + 1'b1;
    end
    if (pop)
    begin
      s_d.rp = (s_q.rp == AW'(D - 1)) ? '0 : s_q.rp + 1'b1;
    end
    s_d.cnt = s_q.cnt + CW'(push) - CW'(pop);
    s_d.full = (s_d.cnt == CW'(D));
    s_d.empty = (s_d.cnt == '0);
  end

  // State register
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.empty <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule

module gwa_top #(
  parameter int LINE_CYCLES = `GWA_LINE_CYCLES,
  parameter int TVDH_CYCLES = `GWA_TVDH_MIN_CYCLES,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clock, // System clock, 250 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [1:0] resolution_select, // Panel line setting
  input wire logic cmd_valid, // Command strobe
  input wire gwa_pkg::gwa_cmd_t cmd, // Opcode and parameters
  input wire logic pix_valid, // Write pixel valid
  input wire gwa_pkg::gwa_pixel_t pix_data, // Write pixel
  output logic pix_ready, // FIFO has room
  input wire logic rd_req, // Read one pixel
  input wire logic gram_ready, // Memory accepts access
  output logic gram_we, // Memory write pulse
  output logic gram_re, // Memory read pulse
  output gwa_pkg::gwa_addr_t gram_addr, // Physical address
  output gwa_pkg::gwa_pixel_t gram_wdata, // Write data
  input wire gwa_pkg::gwa_pixel_t disp_pixel, // Pixel fetched for panel
  output gwa_pkg::gwa_pixel_t src_pixel, // Pixel to source drivers
  output logic [7:0] scan_row, // Row address being scanned
  output logic [7:0] mem_row, // Memory page to display
  output logic row_shown, // Current line is displayed
  output logic tearing_effect, // Tearing effect to host
  output logic panel_en, // Oscillator and panel drive run
  output gwa_pkg::gwa_power_t power_level // Current power level
);
  import gwa_pkg::*;

  typedef struct packed {
    gwa_access_t acc;
    logic [15:0] sc;
    logic [15:0] ec;
    logic [15:0] sp;
    logic [15:0] ep;
    logic [15:0] col;
    logic [15:0] page;
    gwa_acc_t mode;
    gwa_disp_t disp;
    logic sleep;
    logic idle;
    logic te_en;
    logic te_mode;
    logic [15:0] sr;
    logic [15:0] er;
    logic [15:0] top_fixed_lines;
    logic [15:0] scroll_area_lines;
    logic [15:0] bfa;
    logic [15:0] scroll_start_line;
    logic [15:0] line;
    logic [31:0] cyc;
    logic [31:0] hi_cnt;
    logic we;
    logic re;
    gwa_addr_t addr;
    gwa_pixel_t wdata;
    gwa_pixel_t src;
    logic [7:0] scan;
    logic [7:0] mrow;
    logic shown;
    logic te;
    logic panel;
    gwa_power_t power;
  } gwa_state_t;

  gwa_state_t s_q;
  gwa_state_t s_d;
  logic fifo_valid;
  logic fifo_pop;
  logic [17:0] fifo_data;
  logic pix_ready_q;

  // Returns top minus value when mirrored
  function automatic logic [15:0] mirror(input logic [15:0] v, input logic [15:0] top,
                                         input logic en);
    mirror = en ? (top - v) : v;
  endfunction

  // Logical column/page to physical memory address
  function automatic gwa_addr_t map_addr(input logic [15:0] c, input logic [15:0] p,
                                         input gwa_access_t a, input logic gm160);
    logic [15:0] to_col;
    logic [15:0] to_page;
    logic [15:0] ptop;
    logic [15:0] pc;
    logic [15:0] pp;
    to_col = a.row_column_exchange ? p : c;
    to_page = a.row_column_exchange ? c : p;
    ptop = gm160 ? `GWA_PAGE_TOP_160 : `GWA_PAGE_TOP_128;
    pc = mirror(to_col, `GWA_COL_TOP, a.column_mirror);
    pp = mirror(to_page, ptop, a.row_mirror);
    map_addr.col = pc[6:0];
    map_addr.page = pp[7:0];
  endfunction

  gwa_fifo #(
    .W(18),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(pix_valid),
    .in_data(pix_data),
    .in_ready(pix_ready_q),
    .out_ready(fifo_pop),
    .out_valid(fifo_valid),
    .out_data(fifo_data)
  );

  // FIFO full flag is registered inside the FIFO
  assign pix_ready = pix_ready_q;
  assign fifo_pop = (s_q.mode == GWA_ACC_WRITE) & fifo_valid & gram_ready;

  // Next-state logic
  always_comb
  begin
    logic gm160;
    logic go;
    logic vblank;
    logic [15:0] lines;
    logic [15:0] srow;
    logic [15:0] mr;
    logic [15:0] scroll_end;
    logic [15:0] col_n;
    logic [15:0] page_n;
    logic in_part;
    gm160 = 1'b0;
    go = 1'b0;
    vblank = 1'b0;
    lines = '0;
    srow = '0;
    mr = '0;
    scroll_end = '0;
    col_n = '0;
    page_n = '0;
    in_part = 1'b0;
    s_d = s_q;
    s_d.we = 1'b0;
    s_d.re = 1'b0;
    gm160 = (resolution_select == `GWA_GM_160);
    lines = gm160 ? `GWA_LINES_160 : `GWA_LINES_128;

    go = fifo_pop | ((s_q.mode == GWA_ACC_READ) & rd_req & gram_ready);
    if (go)
    begin
      s_d.addr = map_addr(s_q.col, s_q.page, s_q.acc, gm160);
      s_d.wdata = gwa_pixel_t'(fifo_data);
      s_d.we = fifo_pop;
      s_d.re = ~fifo_pop;
      col_n = s_q.col + 16'h0001;
      page_n = s_q.page;
      if (col_n > s_q.ec)
      begin
        col_n = s_q.sc;
        page_n = s_q.page + 16'h0001;
      end
      if (page_n > s_q.ep)
      begin
        col_n = s_q.sc;
        page_n = s_q.sp;
      end
      s_d.col = col_n;
      s_d.page = page_n;
    end

    // Command decode
    if (cmd_valid)
    begin
      case (cmd.opcode)
        `GWA_OP_SLEEP_IN: s_d.sleep = 1'b1;
        `GWA_OP_SLEEP_OUT: s_d.sleep = 1'b0;
        `GWA_OP_IDLE_ON: s_d.idle = 1'b1;
        `GWA_OP_IDLE_OFF: s_d.idle = 1'b0;
        `GWA_OP_PARTIAL_ON: s_d.disp = GWA_DISP_PARTIAL;
        `GWA_OP_NORMAL_ON: s_d.disp = GWA_DISP_NORMAL;
        `GWA_OP_COL_WIN:
        begin
          s_d.sc = cmd.p0;
          s_d.ec = cmd.p1;
        end
        `GWA_OP_PAGE_WIN:
        begin
          s_d.sp = cmd.p0;
          s_d.ep = cmd.p1;
        end
        `GWA_OP_MEM_WR:
        begin
          s_d.col = s_q.sc;
          s_d.page = s_q.sp;
          s_d.mode = GWA_ACC_WRITE;
        end
        `GWA_OP_MEM_RD:
        begin
          s_d.col = s_q.sc;
          s_d.page = s_q.sp;
          s_d.mode = GWA_ACC_READ;
        end
        `GWA_OP_PART_AREA:
        begin
          s_d.sr = cmd.p0;
          s_d.er = cmd.p1;
        end
        `GWA_OP_SCROLL_DEF:
        begin
          s_d.top_fixed_lines = cmd.p0;
          s_d.scroll_area_lines = cmd.p1;
          s_d.bfa = cmd.p2;
        end
        `GWA_OP_TE_OFF: s_d.te_en = 1'b0;
        `GWA_OP_TE_ON:
        begin
          s_d.te_en = 1'b1;
          s_d.te_mode = cmd.p0[`GWA_BIT_TE_MODE];
        end
        `GWA_OP_ACCESS_CTL:
        begin
          s_d.acc.row_mirror = cmd.p0[`GWA_BIT_ROW_MIRROR];
          s_d.acc.column_mirror = cmd.p0[`GWA_BIT_COL_MIRROR];
          s_d.acc.row_column_exchange = cmd.p0[`GWA_BIT_EXCHANGE];
          s_d.acc.scan_order_flip = cmd.p0[`GWA_BIT_SCAN_FLIP];
          s_d.acc.rb_swap = cmd.p0[`GWA_BIT_RB_SWAP];
        end
        `GWA_OP_SCROLL_START:
        begin
          s_d.scroll_start_line = cmd.p0;
          s_d.disp = GWA_DISP_SCROLL;
        end
        default: ;
      endcase
    end

    // sleep halts line timing and panel
    if (s_q.sleep)
    begin
      s_d.cyc = '0;
      s_d.line = '0;
      s_d.hi_cnt = '0;
    end
    else if (s_q.cyc == 32'(LINE_CYCLES - 1))
    begin
      s_d.cyc = '0;
      // hold last blank line until least high time met
      if (s_q.line == `GWA_FRAME_LINES - 16'h0001)
      begin
        if (s_q.hi_cnt >= 32'(TVDH_CYCLES))
        begin
          s_d.line = '0;
        end
      end
      else
      begin
        s_d.line = s_q.line + 16'h0001;
      end
    end
    else
    begin
      s_d.cyc = s_q.cyc + 32'h1;
    end
    s_d.panel = ~s_q.sleep;

    // blank lines follow the active lines
    vblank = (s_q.line >= lines);
    s_d.hi_cnt = (vblank && !s_q.sleep) ? s_q.hi_cnt + 32'h1 : '0;
    // high in blank; on active lines low, or a start pulse in mode 1
    s_d.te = s_q.te_en & ~s_q.sleep & (vblank | (s_q.te_mode & (s_q.cyc < 32'(`GWA_HPULSE_CYCLES))));

    srow = mirror(s_q.line, lines - 16'h0001, s_q.acc.scan_order_flip);
    mr = srow;
    in_part = (s_q.sr <= s_q.er) ? (srow >= s_q.sr && srow <= s_q.er)
                                 : (srow >= s_q.sr || srow <= s_q.er);
    scroll_end = s_q.top_fixed_lines + s_q.scroll_area_lines;
    s_d.shown = ~vblank & ~s_q.sleep;
    unique case (s_q.disp)
      GWA_DISP_NORMAL: mr = srow;
      GWA_DISP_PARTIAL: s_d.shown = ~vblank & ~s_q.sleep & in_part;
      // scroll area rotates by start line
      GWA_DISP_SCROLL:
      begin
        if (srow >= s_q.top_fixed_lines && srow < scroll_end)
        begin
          mr = s_q.scroll_start_line + (srow - s_q.top_fixed_lines);
          if (mr >= scroll_end)
          begin
            mr = mr - s_q.scroll_area_lines;
          end
        end
      end
    endcase
    s_d.scan = srow[7:0];
    s_d.mrow = mr[7:0];

    s_d.src = disp_pixel;
    if (s_q.acc.rb_swap)
    begin
      s_d.src.r = disp_pixel.b;
      s_d.src.b = disp_pixel.r;
    end
    // idle keeps one bit per channel
    if (s_q.idle)
    begin
      s_d.src.r = {6{s_d.src.r[5]}};
      s_d.src.g = {6{s_d.src.g[5]}};
      s_d.src.b = {6{s_d.src.b[5]}};
    end

    if (s_q.sleep)
    begin
      s_d.power = GWA_PWR_SLEEP;
    end
    else if (s_q.disp == GWA_DISP_PARTIAL)
    begin
      s_d.power = s_q.idle ? GWA_PWR_PARTIAL_IDLE : GWA_PWR_PARTIAL;
    end
    else
    begin
      s_d.power = s_q.idle ? GWA_PWR_FULL_IDLE : GWA_PWR_FULL;
    end
  end

  // State register
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.mode <= GWA_ACC_WRITE;
      s_q.disp <= GWA_DISP_NORMAL;
      s_q.power <= GWA_PWR_SLEEP;
      s_q.sleep <= 1'b1;
      s_q.ec <= `GWA_RST_END_COL;
      s_q.ep <= `GWA_RST_END_PAGE;
      s_q.er <= `GWA_RST_END_PAGE;
      s_q.scroll_area_lines <= `GWA_RST_SCROLL_AREA;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign gram_we = s_q.we;
  assign gram_re = s_q.re;
  assign gram_addr = s_q.addr;
  assign gram_wdata = s_q.wdata;
  assign src_pixel = s_q.src;
  assign scan_row = s_q.scan;
  assign mem_row = s_q.mrow;
  assign row_shown = s_q.shown;
  assign tearing_effect = s_q.te;
  assign panel_en = s_q.panel;
  assign power_level = s_q.power;
endmodule

// [verif/gwa_chk_sva.sv]
// Checker for the addressing, power and tearing outputs of gwa_top.
// Assumes one clock domain with a synchronous active low reset.
`timescale 1ns/1ps
module gwa_chk
  import gwa_pkg::*;
#(
  parameter int LINE_CYCLES = 23020,
  parameter int TVDH_CYCLES = 250000,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clock, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [1:0] resolution_select, // Panel line setting
  input wire logic cmd_valid, // Command strobe
  input wire gwa_pkg::gwa_cmd_t cmd, // Opcode and parameters
  input wire logic rd_req, // Read request
  input wire logic gram_ready, // Memory grant
  input wire logic gram_we, // Memory write pulse
  input wire logic gram_re, // Memory read pulse
  input wire gwa_pkg::gwa_addr_t gram_addr, // Physical address
  input wire logic [7:0] scan_row, // Scanned row
  input wire logic row_shown, // Line displayed
  input wire logic tearing_effect, // Tearing output
  input wire logic panel_en, // Panel drive runs
  input wire gwa_pkg::gwa_power_t power_level // Power level
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_one_access: assert property (!(gram_we && gram_re))
    else $error("write and read pulse together");
  a_addr_holds: assert property (!gram_we && !gram_re |-> $stable(gram_addr))
    else $error("address moved without access");
  a_read_cause: assert property (gram_re |-> $past(rd_req && gram_ready))
    else $error("read pulse without granted request");
  a_write_grant: assert property (gram_we |-> $past(gram_ready))
    else $error("write pulse without grant");
  a_power_onehot: assert property ($onehot(power_level))
    else $error("power level not one-hot");
  a_sleep_entry: assert property (cmd_valid && cmd.opcode == 8'h10 ##1 !cmd_valid
    |=> power_level == GWA_PWR_SLEEP) else $error("sleep command not obeyed");
  a_wake_exit: assert property (cmd_valid && cmd.opcode == 8'h11 ##1 !cmd_valid
    |=> power_level != GWA_PWR_SLEEP) else $error("wake command not obeyed");
  a_te_off: assert property (cmd_valid && cmd.opcode == 8'h34 ##1 !cmd_valid
    |=> !tearing_effect) else $error("tearing output still high after off");
  a_sleep_quiet: assert property (!panel_en && $past(!panel_en)
    |-> !tearing_effect && !row_shown) else $error("panel activity in sleep");
  a_scan_bound: assert property (row_shown && $past(resolution_select) == resolution_select
    && $past(resolution_select, 2) == resolution_select
    |-> scan_row < ((resolution_select == 2'h3) ? 8'ha0 : 8'h80))
    else $error("shown row outside panel");
endmodule

bind gwa_top gwa_chk #(.LINE_CYCLES(LINE_CYCLES), .TVDH_CYCLES(TVDH_CYCLES),
  .FIFO_DEPTH(FIFO_DEPTH)) i_chk (.clock(clock), .rst_n(rst_n),
  .resolution_select(resolution_select), .cmd_valid(cmd_valid), .cmd(cmd), .rd_req(rd_req),
  .gram_ready(gram_ready), .gram_we(gram_we), .gram_re(gram_re), .gram_addr(gram_addr),
  .scan_row(scan_row), .row_shown(row_shown), .tearing_effect(tearing_effect),
  .panel_en(panel_en), .power_level(power_level));

// [verif/gwa_mem_model.sv]
// Memory side model: grants accesses, stalls on demand, feeds panel pixels.
// Assumes the block's clock and synchronous active low reset.
`timescale 1ns/1ps
module gwa_mem_model (
  input wire logic clock, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic hold, // Refuse every access
  input wire logic slow, // Grant on some cycles only
  output logic gram_ready, // Access granted
  output gwa_pkg::gwa_pixel_t disp_pixel // Pixel for the panel
);
  import gwa_pkg::*;
  logic [7:0] lfsr_q;

  // Pattern source, changes every cycle
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      lfsr_q <= 8'h5a;
    else
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
  end

  // Grant and fetched pixel
  assign gram_ready = !hold && (!slow || lfsr_q[0]);
  assign disp_pixel = {lfsr_q[5:0], ~lfsr_q[6:1], lfsr_q[7:2]};
endmodule

// [verif/tb.sv]
// Self-checking bench for gwa_top with a memory side model.
// Assumes short line timing parameters so frames stay brief.
`timescale 1ns/1ps
module tb;
  import gwa_pkg::*;
  typedef struct packed {logic rd; gwa_addr_t a; gwa_pixel_t d;} gwa_note_t;
  logic clock = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, pix_valid = 1'b0, rd_req = 1'b0;
  logic hold = 1'b0, slow = 1'b0, chk_src = 1'b0, shown_q = 1'b0;
  logic ex = 1'b0, mx = 1'b0, my = 1'b0;
  logic [1:0] resolution_select = 2'h1;
  gwa_cmd_t cmd = '0;
  gwa_pixel_t pix_data = '0, pd_q = '0, gram_wdata, disp_pixel, src_pixel;
  gwa_addr_t gram_addr;
  gwa_power_t power_level;
  logic pix_ready, gram_ready, gram_we, gram_re, row_shown, tearing_effect, panel_en;
  logic [7:0] scan_row, mem_row;
  logic [31:0] seed = 32'h701b;
  int miscompares = 0, checked = 0, sc = 0, ec = 127, sp = 0, ep = 159, c = 0, p = 0;
  gwa_note_t notes[$];
  logic [7:0] acc[4] = '{8'h00, 8'hc0, 8'h20, 8'he0};
  logic [1:0] res[4] = '{2'h1, 2'h3, 2'h1, 2'h3};
  int win[4][4] = '{'{125, 127, 3, 4}, '{0, 1, 158, 159}, '{10, 12, 0, 1}, '{5, 6, 126, 127}};
  logic [7:0] pops[5] = '{8'h11, 8'h12, 8'h39, 8'h13, 8'h38};
  gwa_power_t plev[5] = '{GWA_PWR_FULL, GWA_PWR_PARTIAL, GWA_PWR_PARTIAL_IDLE,
    GWA_PWR_FULL_IDLE, GWA_PWR_FULL};

  gwa_top #(.LINE_CYCLES(20), .TVDH_CYCLES(50), .FIFO_DEPTH(8)) i_dut (.clock(clock),
    .rst_n(rst_n), .resolution_select(resolution_select), .cmd_valid(cmd_valid), .cmd(cmd),
    .pix_valid(pix_valid), .pix_data(pix_data), .pix_ready(pix_ready), .rd_req(rd_req),
    .gram_ready(gram_ready), .gram_we(gram_we), .gram_re(gram_re), .gram_addr(gram_addr),
    .gram_wdata(gram_wdata), .disp_pixel(disp_pixel), .src_pixel(src_pixel),
    .scan_row(scan_row), .mem_row(mem_row), .row_shown(row_shown),
    .tearing_effect(tearing_effect), .panel_en(panel_en), .power_level(power_level));
  gwa_mem_model i_mem (.clock(clock), .rst_n(rst_n), .hold(hold), .slow(slow),
    .gram_ready(gram_ready), .disp_pixel(disp_pixel));

  // Clock
  always #2 clock = ~clock;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Physical address of the current counters
  function automatic gwa_addr_t phys();
    int x, y;
    x = ex ? p : c;
    y = ex ? c : p;
    if (mx)
      x = 127 - x;
    if (my)
      y = ((resolution_select == 2'h3) ? 161 : 127) - y;
    return {x[6:0], y[7:0]};
  endfunction

  // Counter step inside the window
  function automatic void step();
    c++;
    if (c > ec)
    begin
      c = sc;
      p++;
    end
    if (p > ep)
      {c, p} = {sc, sp};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic send(input logic [7:0] op, input int a, input int b);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd = {op, 16'(a), 16'(b), 16'h0000};
    case (op)
      8'h2a: {sc, ec} = {a, b};
      8'h2b: {sp, ep} = {a, b};
      8'h2c, 8'h2e: {c, p} = {sc, sp};
      8'h36: {my, mx, ex} = a[7:5];
      default: ;
    endcase
    @(negedge clock);
    cmd_valid = 1'b0;
  endtask

  // Offer pixels or reads, noting each one taken
  task automatic burst(input logic rd, input int n);
    int k, g;
    logic ok;
    logic [31:0] r;
    k = 0;
    for (g = 0; k < n && g < 500; g++)
    begin
      @(negedge clock);
      ok = rd ? gram_ready : pix_ready;
      rd_req = rd;
      pix_valid = !rd && ok;
      r = rnd();
      pix_data = r[17:0];
      if (ok === 1'b1)
      begin
        notes.push_back(gwa_note_t'{rd, phys(), pix_data});
        step();
        k++;
      end
    end
    @(negedge clock);
    rd_req = 1'b0;
    pix_valid = 1'b0;
    check(32'(k), 32'(n));
  endtask

  task automatic drain();
    int g;
    for (g = 0; g < 300 && notes.size() > 0; g++)
      @(negedge clock);
    check(32'(notes.size()), 32'h0);
  endtask

  task automatic waitte(input logic v);
    int g;
    for (g = 0; g < 5000 && tearing_effect !== v; g++)
      @(negedge clock);
    if (g == 5000)
    begin
      miscompares++;
      conclude();
    end
  endtask

  // One frame of active lines, counted from the first line after blank
  task automatic rowscan(input int t, input int v, input int s, input int lo, input int hi,
    input logic fl);
    int k, r, m;
    waitte(1'b1);
    waitte(1'b0);
    for (k = 0; k < 3200; k++)
    begin
      r = fl ? 159 - k / 20 : k / 20;
      m = (r >= t && r < t + v) ? t + (s + r - 2 * t) % v : r;
      if (k % 20 == 10)
      begin
        check(32'(scan_row), 32'(r));
        check(32'(mem_row), 32'(m));
        check(32'(row_shown), 32'(r >= lo && r <= hi));
      end
      @(negedge clock);
    end
  endtask

  // Monitor: memory accesses against notes, source pixels against fetch
  always @(negedge clock)
  begin
    gwa_note_t nt;
    if (rst_n && (gram_we === 1'b1 || gram_re === 1'b1))
    begin
      nt = notes.pop_front();
      check(32'(gram_re), 32'(nt.rd));
      check(32'(gram_addr), 32'(nt.a));
      if (!nt.rd)
        check(32'(gram_wdata), 32'(nt.d));
    end
    if (chk_src && shown_q && row_shown === 1'b1)
      check(32'(src_pixel), 32'({{6{pd_q.b[5]}}, {6{pd_q.g[5]}}, {6{pd_q.r[5]}}}));
    pd_q = disp_pixel;
    shown_q = (row_shown === 1'b1);
  end

  // Watchdog
  initial
  begin
    repeat (90000) @(posedge clock);
    miscompares++;
    conclude();
  end

  // Main sequence
  initial
  begin
    int i, n;
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    for (i = 0; i < 5; i++)
    begin
      send(pops[i], 0, 0);
      repeat (2) @(negedge clock);
      check(32'(power_level), 32'(plev[i]));
    end
    for (i = 0; i < 4; i++)
    begin
      resolution_select = res[i];
      slow = seed[3];
      send(8'h36, acc[i], 0);
      send(8'h2a, win[i][0], win[i][1]);
      send(8'h2b, win[i][2], win[i][3]);
      hold = (i == 0);
      send((i == 3) ? 8'h2e : 8'h2c, 0, 0);
      burst(i == 3, 8);
      if (i == 0)
      begin
        check(32'(pix_ready), 32'h0);
        hold = 1'b0;
      end
      drain();
    end
    send(8'h36, 8'h08, 0);
    send(8'h39, 0, 0);
    send(8'h35, 0, 0);
    for (i = 0; i < 2; i++)
    begin
      resolution_select = i ? 2'h3 : 2'h1;
      chk_src = (i == 0);
      waitte(1'b0);
      waitte(1'b1);
      waitte(1'b0);
      waitte(1'b1);
      for (n = 0; n < 2000 && tearing_effect === 1'b1; n++)
        @(negedge clock);
      check(32'(n), 32'((181 - (i ? 160 : 128)) * 20));
    end
    // fixed plus scroll lines total 160
    send(8'h36, 8'h18, 0);
    send(8'h33, 10, 150);
    send(8'h37, 100, 0);
    rowscan(10, 150, 100, 0, 159, 1'b1);
    send(8'h36, 8'h08, 0);
    send(8'h30, 20, 50);
    send(8'h12, 0, 0);
    rowscan(0, 160, 0, 20, 50, 1'b0);
    chk_src = 1'b0;
    send(8'h35, 1, 0);
    send(8'h34, 0, 0);
    repeat (2) @(negedge clock);
    check(32'(tearing_effect), 32'h0);
    send(8'h10, 0, 0);
    repeat (2) @(negedge clock);
    check(32'(power_level), 32'(GWA_PWR_SLEEP));
    check(32'(panel_en), 32'h0);
    send(8'h2c, 0, 0);
    burst(1'b0, 3);
    drain();
    conclude();
  end
endmodule
